// >>> core/dma_put_queue.sv
`timescale 1ns/1ps
module dma_put_queue #(
	parameter int QDEPTH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] ls_addr,
	output logic ls_rd,
	input wire logic [31:0] ls_rdata,
	input wire logic ls_rvalid,
	output logic [63:0] ms_addr,
	output logic [31:0] ms_wdata,
	output logic ms_wr,
	input wire logic ms_ready,
	output logic ms_hint,
	output logic [7:0] ms_class,
	output logic processor_start
);
	localparam int IW = (QDEPTH > 1) ? $clog2(QDEPTH) : 1;
	localparam logic [IW:0] QFULL = (IW + 1)'(QDEPTH);

	// ****************************************
	// parameter registers
	// ****************************************
	logic [7:0] class_reg;
	logic [4:0] tag_reg;
	logic [31:0] size_reg;
	logic [31:0] lsa_reg;
	logic [31:0] eah_reg;
	logic eah_given_reg;
	logic [31:0] eal_reg;
	logic [31:0] def_eah_reg;
	logic err_reg;

	logic pready_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;

	// ****************************************
	// queue storage
	// ****************************************
	logic [7:0] q_class [QDEPTH];
	logic [4:0] q_tag [QDEPTH];
	logic [31:0] q_size [QDEPTH];
	logic [31:0] q_lsa [QDEPTH];
	logic [63:0] q_ea [QDEPTH];
	logic [4:0] q_flag [QDEPTH];
	logic [IW:0] count_reg;
	logic active_reg;
	logic [IW-1:0] active_idx_reg;
	logic go_reg;
	logic start_reg;

	logic mover_busy;
	logic mover_done;
	logic op_legal;
	logic [4:0] op_flags;
	logic is_cmd;
	logic from_proxy;
	logic wr_fire;
	logic enq;
	logic full;
	logic found;
	logic [IW-1:0] pick;
	logic blk;
	logic [31:0] pending_tags;
	logic [31:0] rd_data;
	logic rd_ok;
	logic wr_ok;
	logic [IW:0] wr_idx;

	assign full = count_reg == QFULL;
	assign from_proxy = paddr == dma_pkg::OFF_CMD_PROXY;
	assign is_cmd = (paddr == dma_pkg::OFF_CMD_CHAN) || from_proxy;
	assign wr_fire = psel && penable && pready_reg && pwrite;
	assign enq = wr_fire && is_cmd && op_legal && !full; // R12
	assign wr_idx = count_reg - {{IW{1'b0}}, mover_done};

	command_decode u_decode (
		.opcode(pwdata[15:0]),
		.from_proxy(from_proxy),
		.legal(op_legal),
		.flags(op_flags)
	);

	// ****************************************
	// ordering and selection
	// ****************************************
	// oldest entry not held back by a fence or barrier wins; entry 0 never is, so entries launch in queue order
	always_comb begin
		found = 1'b0;
		pick = '0;
		blk = 1'b0;
		for (int i = 0; i < QDEPTH; i++) begin
			blk = 1'b0;
			for (int j = 0; j < i; j++) begin
				if (q_tag[j] == q_tag[i] && q_flag[i][dma_pkg::F_FENCE]) blk = 1'b1; // R5
				if (q_tag[j] == q_tag[i] && q_flag[i][dma_pkg::F_BARRIER]) blk = 1'b1; // R6
				if (q_tag[j] == q_tag[i] && q_flag[j][dma_pkg::F_BARRIER]) blk = 1'b1; // R6
			end
			if (!found && ((IW + 1)'(i) < count_reg) && !blk) begin // R1
				found = 1'b1;
				pick = IW'(i);
			end
		end
	end

	always_comb begin
		pending_tags = 32'h0;
		for (int i = 0; i < QDEPTH; i++) begin
			if ((IW + 1)'(i) < count_reg) pending_tags[q_tag[i]] = 1'b1;
		end
	end

	// ****************************************
	// launch and completion
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_reg <= 1'b0;
			active_idx_reg <= '0;
			go_reg <= 1'b0;
		end else begin
			go_reg <= 1'b0;
			if (mover_done) begin
				active_reg <= 1'b0;
			end else if (!active_reg && found && !mover_busy) begin
				active_reg <= 1'b1;
				active_idx_reg <= pick;
				go_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_reg <= 1'b0;
		end else begin
			start_reg <= mover_done && q_flag[active_idx_reg][dma_pkg::F_START]; // R3
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= '0;
		end else begin
			count_reg <= wr_idx + {{IW{1'b0}}, enq};
		end
	end

	// entries above the finished one move down, new entry lands on top
	always_ff @(posedge pclk) begin
		if (mover_done) begin
			for (int i = 0; i < QDEPTH - 1; i++) begin
				if (IW'(i) >= active_idx_reg) begin
					q_class[i] <= q_class[i + 1];
					q_tag[i] <= q_tag[i + 1];
					q_size[i] <= q_size[i + 1];
					q_lsa[i] <= q_lsa[i + 1];
					q_ea[i] <= q_ea[i + 1];
					q_flag[i] <= q_flag[i + 1];
				end
			end
		end
		if (enq) begin
			q_class[wr_idx[IW-1:0]] <= class_reg; // R11
			q_tag[wr_idx[IW-1:0]] <= tag_reg;
			q_size[wr_idx[IW-1:0]] <= size_reg; // R7
			q_lsa[wr_idx[IW-1:0]] <= lsa_reg;
			q_ea[wr_idx[IW-1:0]] <= {eah_given_reg ? eah_reg : def_eah_reg, eal_reg}; // R10 R8
			q_flag[wr_idx[IW-1:0]] <= op_flags; // R4
		end
	end

	put_mover u_mover (
		.pclk(pclk),
		.presetn(presetn),
		.go(go_reg),
		.is_list(q_flag[active_idx_reg][dma_pkg::F_LIST]),
		.local_address(q_lsa[active_idx_reg]),
		.ea(q_ea[active_idx_reg]),
		.size(q_size[active_idx_reg]),
		.class_in(q_class[active_idx_reg]),
		.hint(q_flag[active_idx_reg][dma_pkg::F_HINT]),
		.busy(mover_busy),
		.done(mover_done),
		.ls_addr(ls_addr),
		.ls_rd(ls_rd),
		.ls_rdata(ls_rdata),
		.ls_rvalid(ls_rvalid),
		.ms_addr(ms_addr),
		.ms_wdata(ms_wdata),
		.ms_wr(ms_wr),
		.ms_ready(ms_ready),
		.ms_hint(ms_hint),
		.ms_class(ms_class)
	);

	// ****************************************
	// register writes
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			class_reg <= 8'h00;
			tag_reg <= 5'h00;
			size_reg <= 32'h0;
			lsa_reg <= 32'h0;
			eah_reg <= 32'h0;
			eal_reg <= 32'h0;
			def_eah_reg <= dma_pkg::DEF_EAH_RST;
		end else if (wr_fire) begin
			unique case (paddr)
				dma_pkg::OFF_CLASS: class_reg <= pwdata[7:0]; // R11
				dma_pkg::OFF_TAG: tag_reg <= pwdata[4:0];
				dma_pkg::OFF_SIZE: size_reg <= pwdata;
				dma_pkg::OFF_LSA: lsa_reg <= pwdata;
				dma_pkg::OFF_EAH: eah_reg <= pwdata;
				dma_pkg::OFF_EAL: eal_reg <= pwdata;
				dma_pkg::OFF_DEF_EAH: def_eah_reg <= pwdata;
				default: ;
			endcase
		end
	end

	// upper address counts as given only until the next command uses it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eah_given_reg <= 1'b0;
		end else if (wr_fire && paddr == dma_pkg::OFF_EAH) begin
			eah_given_reg <= 1'b1;
		end else if (enq) begin
			eah_given_reg <= 1'b0; // R10
		end
	end

	// bad opcode or full queue sets the error; the set beats a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_reg <= 1'b0;
		end else if (wr_fire && is_cmd && (!op_legal || full)) begin
			err_reg <= 1'b1; // R12
		end else if (wr_fire && paddr == dma_pkg::OFF_STATUS && pwdata[dma_pkg::ST_ERR]) begin
			err_reg <= 1'b0;
		end
	end

	// ****************************************
	// apb read and answer
	// ****************************************
	always_comb begin
		rd_data = 32'h0;
		rd_ok = 1'b1;
		wr_ok = 1'b1;
		unique case (paddr)
			dma_pkg::OFF_CLASS: rd_data = {24'h0, class_reg};
			dma_pkg::OFF_TAG: rd_data = {27'h0, tag_reg};
			dma_pkg::OFF_SIZE: rd_data = size_reg;
			dma_pkg::OFF_LSA: rd_data = lsa_reg;
			dma_pkg::OFF_EAH: rd_data = eah_reg;
			dma_pkg::OFF_EAL: rd_data = eal_reg;
			dma_pkg::OFF_DEF_EAH: rd_data = def_eah_reg;
			dma_pkg::OFF_CMD_CHAN, dma_pkg::OFF_CMD_PROXY: begin
				rd_data = 32'h0;
				wr_ok = op_legal && !full;
			end
			dma_pkg::OFF_STATUS: begin
				rd_data[dma_pkg::ST_BUSY] = active_reg;
				rd_data[dma_pkg::ST_FULL] = full;
				rd_data[dma_pkg::ST_ERR] = err_reg;
				rd_data[dma_pkg::ST_CNT +: IW + 1] = count_reg;
			end
			dma_pkg::OFF_TAGS: begin
				rd_data = pending_tags;
				wr_ok = 1'b0;
			end
			default: begin
				rd_ok = 1'b0;
				wr_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			prdata_reg <= 32'h0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= psel && penable && !pready_reg;
			if (psel && penable && !pready_reg) begin
				prdata_reg <= pwrite ? 32'h0 : rd_data;
				pslverr_reg <= pwrite ? !wr_ok : !rd_ok;
			end else begin
				pslverr_reg <= 1'b0;
			end
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign processor_start = start_reg;
endmodule

// >>> core/dma_pkg.sv
// Behaviour
// R1: queued commands may complete out of order; the queue always runs them one at a time in queue order
// R2: store copies local bytes to main storage
// R3: store-and-start only from proxy; starts processor
// R4: cache-injection stores carry level-two hint
// R5: fenced store waits for earlier same-tag commands
// R6: barrier holds itself and later same-tag commands
// R7: size register is byte count or list length
// R8: low address is main address or list pointer
// R9: list elements fetched from local storage
// R10: missing upper address uses default value
// R11: issuer supplies class, tag, size, addresses
// R12: undefined or misrouted opcode rejected with error
package dma_pkg;
	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] OFF_CLASS = 8'h00;
	localparam logic [7:0] OFF_TAG = 8'h04;
	localparam logic [7:0] OFF_SIZE = 8'h08;
	localparam logic [7:0] OFF_LSA = 8'h0c;
	localparam logic [7:0] OFF_EAH = 8'h10;
	localparam logic [7:0] OFF_EAL = 8'h14;
	localparam logic [7:0] OFF_CMD_CHAN = 8'h18;
	localparam logic [7:0] OFF_CMD_PROXY = 8'h1c;
	localparam logic [7:0] OFF_STATUS = 8'h20;
	localparam logic [7:0] OFF_TAGS = 8'h24;
	localparam logic [7:0] OFF_DEF_EAH = 8'h28;
	// ****************************************
	// status fields and reset values
	// ****************************************
	localparam int ST_BUSY = 0;
	localparam int ST_FULL = 1;
	localparam int ST_ERR = 2;
	localparam int ST_CNT = 8;
	localparam logic [31:0] DEF_EAH_RST = 32'h0000_0000;
	// ****************************************
	// command flag positions, list element layout and word size
	// ****************************************
	localparam int F_BARRIER = 0;
	localparam int F_FENCE = 1;
	localparam int F_LIST = 2;
	localparam int F_START = 3;
	localparam int F_HINT = 4;
	localparam int ELEM_SHIFT = 3;
	localparam logic [31:0] ELEM_ADR_OFS = 32'h0000_0004;
	localparam logic [31:0] ELEM_BYTES = 32'h0000_0008;
	localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
	// ****************************************
	// opcodes
	// ****************************************
	localparam logic [15:0] OP_STORE = 16'h0020;
	localparam logic [15:0] OP_STORE_B = 16'h0021;
	localparam logic [15:0] OP_STORE_F = 16'h0022;
	localparam logic [15:0] OP_STORE_L = 16'h0024;
	localparam logic [15:0] OP_STORE_LB = 16'h0025;
	localparam logic [15:0] OP_STORE_LF = 16'h0026;
	localparam logic [15:0] OP_START = 16'h0028;
	localparam logic [15:0] OP_START_B = 16'h0029;
	localparam logic [15:0] OP_START_F = 16'h002a;
	localparam logic [15:0] OP_HINT = 16'h0030;
	localparam logic [15:0] OP_HINT_B = 16'h0031;
	localparam logic [15:0] OP_HINT_F = 16'h0032;
	localparam logic [15:0] OP_HINT_L = 16'h0034;
	localparam logic [15:0] OP_HINT_LB = 16'h0035;
	localparam logic [15:0] OP_HINT_LF = 16'h0036;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_FETCH_CNT = 3'b001,
		S_FETCH_ADR = 3'b011,
		S_READ = 3'b010,
		S_WRITE = 3'b110
	} mover_state_t;
endpackage

// >>> core/command_decode.sv
`timescale 1ns/1ps
module command_decode (
	input wire logic [15:0] opcode,
	input wire logic from_proxy,
	output logic legal,
	output logic [4:0] flags
);
	logic known;
	always_comb begin
		unique case (opcode)
			dma_pkg::OP_STORE, dma_pkg::OP_STORE_B, dma_pkg::OP_STORE_F,
			dma_pkg::OP_STORE_L, dma_pkg::OP_STORE_LB, dma_pkg::OP_STORE_LF,
			dma_pkg::OP_START, dma_pkg::OP_START_B, dma_pkg::OP_START_F,
			dma_pkg::OP_HINT, dma_pkg::OP_HINT_B, dma_pkg::OP_HINT_F,
			dma_pkg::OP_HINT_L, dma_pkg::OP_HINT_LB, dma_pkg::OP_HINT_LF: known = 1'b1;
			default: known = 1'b0; // R12
		endcase
	end
	// modifier bits of the opcode give barrier, fence, list, start and hint
	assign flags = opcode[4:0];
	// start variants proxy only, list variants channel only
	assign legal = known && !(flags[dma_pkg::F_START] && !from_proxy) // R3 R12
		&& !(flags[dma_pkg::F_LIST] && from_proxy);
endmodule

// >>> core/put_mover.sv
`timescale 1ns/1ps
module put_mover (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire logic is_list,
	input wire logic [31:0] local_address,
	input wire logic [63:0] ea,
	input wire logic [31:0] size,
	input wire logic [7:0] class_in,
	input wire logic hint,
	output logic busy,
	output logic done,
	output logic [31:0] ls_addr,
	output logic ls_rd,
	input wire logic [31:0] ls_rdata,
	input wire logic ls_rvalid,
	output logic [63:0] ms_addr,
	output logic [31:0] ms_wdata,
	output logic ms_wr,
	input wire logic ms_ready,
	output logic ms_hint,
	output logic [7:0] ms_class
);
	dma_pkg::mover_state_t state;
	logic wait_r;
	logic list_mode;
	logic [31:0] words;
	logic [31:0] elems;
	logic [31:0] list_ptr;
	logic [31:0] lsa_r;
	logic [63:0] ea_r;
	logic [31:0] ea_hi;

	function automatic logic [31:0] word_count(input logic [31:0] bytes);
		logic [32:0] sum;
		sum = {1'b0, bytes} + 33'h0_0000_0003;
		return {1'b0, sum[32:2]};
	endfunction

	assign busy = state != dma_pkg::S_IDLE;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= dma_pkg::S_IDLE;
			wait_r <= 1'b0;
			list_mode <= 1'b0;
			words <= 32'h0;
			elems <= 32'h0;
			list_ptr <= 32'h0;
			lsa_r <= 32'h0;
			ea_r <= 64'h0;
			ea_hi <= 32'h0;
			done <= 1'b0;
			ls_addr <= 32'h0;
			ls_rd <= 1'b0;
			ms_addr <= 64'h0;
			ms_wdata <= 32'h0;
			ms_wr <= 1'b0;
			ms_hint <= 1'b0;
			ms_class <= 8'h00;
		end else begin
			done <= 1'b0;
			ls_rd <= 1'b0;
			unique case (state)
				dma_pkg::S_IDLE: begin
					if (go) begin
						ms_hint <= hint; // R4
						ms_class <= class_in;
						ea_hi <= ea[63:32];
						lsa_r <= local_address;
						list_mode <= is_list;
						if (is_list) begin
							list_ptr <= ea[31:0]; // R8
							elems <= size >> dma_pkg::ELEM_SHIFT; // R7
							words <= 32'h0;
							state <= dma_pkg::S_FETCH_CNT;
						end else begin
							ea_r <= ea; // R8
							words <= word_count(size); // R7
							state <= dma_pkg::S_READ;
						end
					end
				end
				dma_pkg::S_FETCH_CNT: begin
					if (elems == 32'h0) begin
						done <= 1'b1;
						state <= dma_pkg::S_IDLE;
					end else if (!wait_r) begin
						ls_addr <= list_ptr; // R9
						ls_rd <= 1'b1;
						wait_r <= 1'b1;
					end else if (ls_rvalid) begin
						wait_r <= 1'b0;
						words <= word_count(ls_rdata); // R9
						state <= dma_pkg::S_FETCH_ADR;
					end
				end
				dma_pkg::S_FETCH_ADR: begin
					if (!wait_r) begin
						ls_addr <= list_ptr + dma_pkg::ELEM_ADR_OFS; // R9
						ls_rd <= 1'b1;
						wait_r <= 1'b1;
					end else if (ls_rvalid) begin
						wait_r <= 1'b0;
						ea_r <= {ea_hi, ls_rdata};
						list_ptr <= list_ptr + dma_pkg::ELEM_BYTES;
						elems <= elems - 32'h1;
						state <= dma_pkg::S_READ;
					end
				end
				dma_pkg::S_READ: begin
					if (words == 32'h0) begin
						if (list_mode) begin
							state <= dma_pkg::S_FETCH_CNT;
						end else begin
							done <= 1'b1;
							state <= dma_pkg::S_IDLE;
						end
					end else if (!wait_r) begin
						ls_addr <= lsa_r; // R2
						ls_rd <= 1'b1;
						wait_r <= 1'b1;
					end else if (ls_rvalid) begin
						wait_r <= 1'b0;
						ms_addr <= ea_r;
						ms_wdata <= ls_rdata; // R2
						ms_wr <= 1'b1;
						state <= dma_pkg::S_WRITE;
					end
				end
				dma_pkg::S_WRITE: begin
					if (ms_ready) begin
						ms_wr <= 1'b0;
						lsa_r <= lsa_r + dma_pkg::WORD_BYTES;
						ea_r <= ea_r + {32'h0, dma_pkg::WORD_BYTES};
						words <= words - 32'h1;
						state <= dma_pkg::S_READ;
					end
				end
				default: state <= dma_pkg::S_IDLE;
			endcase
		end
	end
endmodule

// >>> dv/dma_put_queue_sva.sv
`timescale 1ns/1ps
module dma_put_queue_chk #(
	parameter int QDEPTH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ls_rd,
	input wire logic ls_rvalid,
	input wire logic [63:0] ms_addr,
	input wire logic [31:0] ms_wdata,
	input wire logic ms_wr,
	input wire logic ms_ready,
	input wire logic processor_start
);
	// ****
	// port relations
	// ****
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic cmd_wr;
	assign cmd_wr = psel && penable && pready && pwrite;
	a_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_ready: assert property (pslverr |-> pready && psel && penable)
		else $error("pslverr outside an answer");
	a_chan_start: assert property (cmd_wr && paddr == dma_pkg::OFF_CMD_CHAN
		&& pwdata[15:0] inside {16'h0028, 16'h0029, 16'h002a} |-> pslverr)
		else $error("start command accepted on channel");
	a_proxy_list: assert property (cmd_wr && paddr == dma_pkg::OFF_CMD_PROXY
		&& pwdata[15:0] inside {16'h0024, 16'h0025, 16'h0026, 16'h0034, 16'h0035, 16'h0036}
		|-> pslverr)
		else $error("list command accepted on proxy");
	a_ms_hold: assert property (ms_wr && !ms_ready |=> ms_wr && $stable(ms_addr)
		&& $stable(ms_wdata))
		else $error("write request changed before ready");
	a_word_gap: assert property (ms_wr && ms_ready |=> !ms_wr)
		else $error("next word without a read between");
	a_data_first: assert property ($rose(ms_wr) |-> $past(ls_rvalid))
		else $error("write not preceded by read data");
	a_rd_pulse: assert property (ls_rd |=> !ls_rd)
		else $error("read request longer than one cycle");
	a_start_late: assert property (processor_start |-> $past(ms_wr && ms_ready, 2)
		|| $past(ms_wr && ms_ready, 3))
		else $error("start pulse not after last word");
endmodule
bind dma_put_queue dma_put_queue_chk #(.QDEPTH(QDEPTH)) chk (.pclk, .presetn, .paddr, .psel,
	.penable, .pwrite, .pwdata, .pready, .pslverr, .ls_rd, .ls_rvalid, .ms_addr, .ms_wdata,
	.ms_wr, .ms_ready, .processor_start);

// >>> dv/storage_model.sv
`timescale 1ns/1ps
module storage_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [31:0] ls_addr,
	input wire logic ls_rd,
	output logic [31:0] ls_rdata,
	output logic ls_rvalid,
	input wire logic [63:0] ms_addr,
	input wire logic [31:0] ms_wdata,
	input wire logic ms_wr,
	output logic ms_ready,
	input wire logic ms_hint,
	input wire logic [7:0] ms_class,
	input wire logic stall,
	input wire logic slow
);
	// ****
	// local and main storage
	// ****
	logic [31:0] mem [logic [31:0]];
	logic [95:0] wlog [$];
	logic [8:0] wside [$];
	logic [31:0] rd_a;
	int rd_wait;
	int rdy_cnt;
	// idle data bus toggles so a stale word is never mistaken for fresh data
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ls_rvalid <= 1'b0;
			ls_rdata <= 32'h0;
			rd_wait <= 0;
		end else begin
			ls_rvalid <= 1'b0;
			ls_rdata <= ~ls_rdata;
			if (ls_rd) begin
				rd_a <= ls_addr;
				rd_wait <= slow ? 3 : 1;
			end else if (rd_wait > 1) begin
				rd_wait <= rd_wait - 1;
			end else if (rd_wait == 1) begin
				rd_wait <= 0;
				ls_rvalid <= 1'b1;
				ls_rdata <= mem.exists(rd_a) ? mem[rd_a] : {rd_a[15:0], ~rd_a[15:0]};
			end
		end
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_ready <= 1'b0;
			rdy_cnt <= 0;
		end else begin
			rdy_cnt <= rdy_cnt + 1;
			ms_ready <= !stall && (!slow || rdy_cnt % 3 == 0);
			if (ms_wr && ms_ready) begin
				wlog.push_back({ms_addr, ms_wdata});
				wside.push_back({ms_hint, ms_class});
			end
		end
	end
endmodule

// >>> dv/tb.sv
`timescale 1ns/1ps
`define CHK(nm, xv, gv) begin \
	num_checks++; \
	if ((gv) !== (xv)) begin \
		bad_count++; \
		$display("Error %s expected %h seen %h", nm, xv, gv); \
	end \
end
module tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic stall = 1'b0;
	logic slow = 1'b0;
	logic [31:0] prdata, ls_addr, ls_rdata, ms_wdata, r, wd, lsv;
	logic pready, pslverr, ls_rd, ls_rvalid, ms_wr, ms_ready, ms_hint, processor_start, e;
	logic [63:0] ms_addr, wa;
	logic [7:0] ms_class;
	logic [8:0] ws;
	int bad_count = 0;
	int num_checks = 0;
	int starts = 0;
	int pos [4];
	logic [15:0] ops [5] = '{dma_pkg::OP_STORE, dma_pkg::OP_HINT, dma_pkg::OP_HINT_F,
		dma_pkg::OP_STORE_F, dma_pkg::OP_STORE_B};
	logic [15:0] sops [3] = '{dma_pkg::OP_START, dma_pkg::OP_START_B, dma_pkg::OP_START_F};
	logic [15:0] bad [6] = '{dma_pkg::OP_START, dma_pkg::OP_START_B, dma_pkg::OP_START_F,
		16'h0040, 16'h0023, dma_pkg::OP_STORE_L};
	logic [15:0] qops [5] = '{dma_pkg::OP_STORE, dma_pkg::OP_STORE_B, dma_pkg::OP_STORE,
		dma_pkg::OP_STORE_F, dma_pkg::OP_STORE};
	dma_put_queue #(.QDEPTH(4)) dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .ls_addr, .ls_rd, .ls_rdata, .ls_rvalid, .ms_addr, .ms_wdata,
		.ms_wr, .ms_ready, .ms_hint, .ms_class, .processor_start);
	storage_model far (.pclk, .presetn, .ls_addr, .ls_rd, .ls_rdata, .ls_rvalid, .ms_addr,
		.ms_wdata, .ms_wr, .ms_ready, .ms_hint, .ms_class, .stall, .slow);
	initial forever #25 pclk = ~pclk;
	always @(posedge pclk) if (processor_start === 1'b1) starts++;
	// ****
	// bus tasks
	// ****
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n = 0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) bad_count++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
		apb(a, 1'b1, d);
		`CHK("write pslverr", xe, e)
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] xd, input logic xe);
		apb(a, 1'b0, 32'h0);
		`CHK("read pslverr", xe, e)
		`CHK("prdata", xd, r)
	endtask
	task automatic cmd(input logic [4:0] tg, input logic [31:0] sz, ls, ea,
		input logic [15:0] op, input logic px, input logic xe);
		wr(dma_pkg::OFF_CLASS, {24'h0, 3'b010, tg}, 1'b0);
		wr(dma_pkg::OFF_TAG, {27'h0, tg}, 1'b0);
		wr(dma_pkg::OFF_SIZE, sz, 1'b0);
		wr(dma_pkg::OFF_LSA, ls, 1'b0);
		wr(dma_pkg::OFF_EAL, ea, 1'b0);
		wr(px ? dma_pkg::OFF_CMD_PROXY : dma_pkg::OFF_CMD_CHAN, {16'h0, op}, xe);
	endtask
	task automatic pop();
		int n = 0;
		while (far.wlog.size() == 0 && n < 400) begin
			@(posedge pclk);
			n++;
		end
		if (far.wlog.size() == 0) begin
			bad_count++;
		end else begin
			{wa, wd} = far.wlog.pop_front();
			ws = far.wside.pop_front();
		end
	endtask
	task automatic ew(input logic [63:0] xa, input logic [31:0] ls, input logic h,
		input logic [4:0] tg);
		pop();
		`CHK("ms_addr", xa, wa)
		`CHK("ms_wdata", {ls[15:0], ~ls[15:0]}, wd)
		`CHK("ms_hint and ms_class", {h, 3'b010, tg}, ws)
	endtask
	task summarize;
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ****
	// tests
	// ****
	initial begin
		repeat (30000) @(posedge pclk);
		bad_count++;
		summarize();
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(dma_pkg::OFF_STATUS, 32'h0, 1'b0);
		rd(dma_pkg::OFF_DEF_EAH, dma_pkg::DEF_EAH_RST, 1'b0);
		rd(8'h2c, 32'h0, 1'b1);
		wr(dma_pkg::OFF_TAGS, 32'h1, 1'b1);
		wr(dma_pkg::OFF_DEF_EAH, 32'hab, 1'b0);
		rd(dma_pkg::OFF_DEF_EAH, 32'hab, 1'b0);
		cmd(5'd1, 32'd6, 32'h100, 32'h2000, dma_pkg::OP_STORE, 1'b0, 1'b0);
		ew({32'hab, 32'h2000}, 32'h100, 1'b0, 5'd1);
		ew({32'hab, 32'h2004}, 32'h104, 1'b0, 5'd1);
		for (int i = 0; i < 10; i++) begin
			slow <= (i >= 5);
			cmd(5'd2, 32'd4, 32'h200 + 16 * i, 32'h3000 + 16 * i, ops[i % 5], i >= 5, 1'b0);
			ew({32'hab, 32'h3000 + 16 * i}, 32'h200 + 16 * i, (i % 5 == 1) || (i % 5 == 2), 5'd2);
		end
		for (int i = 0; i < 3; i++) begin
			cmd(5'd4, 32'd4, 32'h280, 32'h3800, sops[i], 1'b1, 1'b0);
			ew({32'hab, 32'h3800}, 32'h280, 1'b0, 5'd4);
		end
		slow <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			cmd(5'd6, 32'd4, 32'h2c0, 32'h3c00, bad[i], i == 5, 1'b1);
			rd(dma_pkg::OFF_STATUS, 32'h4, 1'b0);
			wr(dma_pkg::OFF_STATUS, 32'h4, 1'b0);
		end
		rd(dma_pkg::OFF_STATUS, 32'h0, 1'b0);
		`CHK("refused writes", 0, far.wlog.size())
		`CHK("start pulses", 3, starts)
		far.mem[32'h300] = 32'd8;
		far.mem[32'h304] = 32'h4000;
		far.mem[32'h308] = 32'd4;
		far.mem[32'h30c] = 32'h5000;
		wr(dma_pkg::OFF_EAH, 32'h12, 1'b0);
		cmd(5'd7, 32'd16, 32'h180, 32'h300, dma_pkg::OP_STORE_L, 1'b0, 1'b0);
		ew({32'h12, 32'h4000}, 32'h180, 1'b0, 5'd7);
		ew({32'h12, 32'h4004}, 32'h184, 1'b0, 5'd7);
		ew({32'h12, 32'h5000}, 32'h188, 1'b0, 5'd7);
		stall <= 1'b1;
		wr(dma_pkg::OFF_EAH, 32'h12, 1'b0);
		for (int i = 0; i < 5; i++)
			cmd(5'd3, 32'd4, 32'h400 + 4 * i, 32'h6000 + 256 * i, qops[i], 1'b0, i == 4);
		rd(dma_pkg::OFF_STATUS, 32'h407, 1'b0);
		rd(dma_pkg::OFF_TAGS, 32'h8, 1'b0);
		stall <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			pop();
			pos[wa[9:8]] = k;
			lsv = 32'h400 + 32'(wa[9:8]) * 4;
			`CHK("ms_wdata", {lsv[15:0], ~lsv[15:0]}, wd)
			`CHK("ms_addr upper", (wa[9:8] == 2'd0) ? 32'h12 : 32'hab, wa[63:32])
		end
		`CHK("barrier order", 1'b1, pos[0] < pos[1] && pos[1] < pos[2])
		`CHK("fence order", 1'b1, pos[2] < pos[3])
		summarize();
	end
endmodule
